/* hw/sofm_pkg.sv */
// Package: register map, fields and timing constants of the output feedback monitor
package sofm_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned FB_WINDOW_MS = 500;
  localparam int unsigned FB_WINDOW_CYC = FB_WINDOW_MS * (CLK_HZ / 1000);
  localparam int unsigned FILT_LEN = 4;
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STAT_OFS = 12'h004;
  localparam logic [11:0] IRQ_STAT_OFS = 12'h008;
  localparam logic [11:0] IRQ_MASK_OFS = 12'h00C;
  localparam logic [11:0] ACK_OFS = 12'h010;
  localparam int unsigned CTRL_FB_EN = 0;
  localparam int unsigned CTRL_REF_EN = 1;
  localparam int unsigned CTRL_SHOCK_EXP = 2;
  localparam int unsigned CTRL_ENGINEER = 3;
  localparam int unsigned CTRL_RESTART_LOCK = 4;
  localparam logic [31:0] CTRL_RST = 32'h0000_0011;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;
  localparam logic [31:0] ACK_KEY = 32'h0000_A5C3;
  localparam int unsigned EV_FB_FAULT = 0;
  localparam int unsigned EV_REF_FAULT = 1;
  localparam int unsigned EV_SHOCK = 2;
  localparam int unsigned EV_OUT_ON = 3;
  localparam int unsigned EV_OUT_OFF = 4;
  localparam int unsigned EV_W = 5;
  localparam logic [7:0] MSG_NONE = 8'h00;
  localparam logic [7:0] MSG_FB_OPEN = 8'h01;
  localparam logic [7:0] MSG_FB_CLOSE = 8'h02;
  localparam logic [7:0] MSG_FB_PRE = 8'h03;
  localparam logic [7:0] MSG_SHOCK = 8'h10;
  typedef enum logic [2:0] {SOFM_OFF, SOFM_ON, SOFM_CHK_OPEN, SOFM_CHK_CLOSE, SOFM_INTERLOCK} sofm_state_e;
endpackage

/* hw/sofm_sync_filter.sv */
// Two-flop synchroniser followed by a stable-count glitch filter
`timescale 1ns/10ps
module sofm_sync_filter #(
  parameter int unsigned LEN = 4
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic async_i,
  input wire logic rst_val_i,
  output logic filt_o
);
  import sofm_pkg::*;
  logic s1;
  logic s2;
  logic [$clog2(LEN+1)-1:0] cnt;
  wire differs = (s2 != filt_o);
  wire done = (cnt == ($clog2(LEN+1))'(LEN - 1));
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      cnt <= '0;
      filt_o <= 1'b0;
    end else begin
      s1 <= async_i;
      s2 <= s1;
      cnt <= (differs && !done) ? cnt + 1'b1 : '0;
      if (differs && done) begin
        filt_o <= s2;
      end
    end
  end
endmodule

/* hw/sofm_window_timer.sv */
// Down-counter that times one feedback window
`timescale 1ns/10ps
module sofm_window_timer #(
  parameter int unsigned CYC = 5_000_000
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic start_i,
  input wire logic stop_i,
  output logic expired_o
);
  import sofm_pkg::*;
  logic [$clog2(CYC+1)-1:0] cnt;
  logic run;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt <= '0;
      run <= 1'b0;
      expired_o <= 1'b0;
    end else begin
      expired_o <= 1'b0;
      if (start_i) begin
        cnt <= ($clog2(CYC+1))'(CYC - 1);
        run <= 1'b1;
      end else if (stop_i) begin
        run <= 1'b0;
      end else if (run) begin
        if (cnt == '0) begin
          run <= 1'b0;
          expired_o <= 1'b1;
        end else begin
          cnt <= cnt - 1'b1;
        end
      end
    end
  end
endmodule

/* hw/sofm_top.sv */
// Safety output feedback monitor: contour check, contactor feedback, shock ack, APB regs
// Contract
// - Check reference contour besides field interruption
// - Contour deviation forces all outputs off
// - Feedback checking only when enabled, dynamic
// - Feedback must be closed before switch-on
// - Feedback must open within 500 ms
// - Feedback must close within 500 ms
// - Feedback fault: outputs off, message, interlock
// - Shock ack via input when not expanded
// - Expanded: ack only via engineer session
`timescale 1ns/10ps
module sofm_top #(
  parameter int unsigned FB_WINDOW_CYCLES = sofm_pkg::FB_WINDOW_CYC,
  parameter int unsigned FILTER_LEN = sofm_pkg::FILT_LEN
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic field_clear_i,
  input wire logic ref_area_present_i,
  input wire logic ref_contour_ok_i,
  input wire logic start_restart_lock_i,
  input wire logic contactor_feedback_input_i,
  input wire logic shock_error_i,
  input wire logic ack_input_i,
  output logic safety_switched_output_o,
  output logic fault_interlock_o,
  output logic [7:0] display_msg_o,
  output logic irq_o
);
  import sofm_pkg::*;

  // Outputs are released in both of these states
  function automatic logic drives_outputs(input sofm_state_e s);
    return (s == SOFM_ON) || (s == SOFM_CHK_OPEN);
  endfunction

  sofm_state_e state;
  sofm_state_e next_state;
  logic [31:0] ctrl;
  logic [31:0] irq_stat;
  logic [31:0] irq_mask;
  logic shock_latched;
  logic ref_fault;
  logic fb_closed;
  logic ack_s1;
  logic ack_s2;
  logic ack_prev;
  logic [7:0] next_msg;

  // Pin inputs from the field side pass two flops
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
    end else begin
      pin_s1 <= {field_clear_i, ref_area_present_i, ref_contour_ok_i, shock_error_i};
      pin_s2 <= pin_s1;
    end
  end
  wire field_clear = pin_s2[3];
  wire ref_present = pin_s2[2];
  wire ref_ok = pin_s2[1];
  wire shock_err = pin_s2[0];

  // Filter delays each feedback edge by a few cycles, far below the window
  sofm_sync_filter #(.LEN(FILTER_LEN)) u_fb_filter (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .async_i(contactor_feedback_input_i),
    .rst_val_i(1'b0),
    .filt_o(fb_closed)
  );

  // Feedback expected closed while outputs off, open while on

  wire fb_en = ctrl[CTRL_FB_EN];
  wire ref_en = ctrl[CTRL_REF_EN];
  // Contour check only in fields that hold a reference area
  wire ref_dev = ref_en && ref_present && !ref_ok;
  wire out_active = drives_outputs(state);

  // Start permission comes from the upstream lock input when interlocking
  wire lock_mode = ctrl[CTRL_RESTART_LOCK];
  // Level from the upstream lock logic, which times the button press
  wire start_ok = lock_mode ? start_restart_lock_i : 1'b1;
  // Any latched fault keeps the outputs off until acknowledged
  wire ready_to_start = field_clear && !ref_dev && !shock_latched && !ref_fault;
  wire pre_check_ok = !fb_en || fb_closed;

  logic win_start;
  logic win_stop;
  logic win_expired;
  // Expiry is a one-cycle pulse; only the check states look at it
  sofm_window_timer #(.CYC(FB_WINDOW_CYCLES)) u_window (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .start_i(win_start),
    .stop_i(win_stop),
    .expired_o(win_expired)
  );

  // APB decode
  wire apb_acc = psel_i && penable_i;
  wire wr = apb_acc && pwrite_i;
  wire rd = apb_acc && !pwrite_i;
  wire sel_ctrl = (paddr_i == CTRL_OFS);
  wire sel_stat = (paddr_i == STAT_OFS);
  wire sel_istat = (paddr_i == IRQ_STAT_OFS);
  wire sel_imask = (paddr_i == IRQ_MASK_OFS);
  wire sel_ack = (paddr_i == ACK_OFS);
  wire mapped = sel_ctrl || sel_stat || sel_istat || sel_imask || sel_ack;
  wire ack_cmd = wr && sel_ack && (pwdata_i == ACK_KEY);

  // Acknowledge edge from the pin
  wire ack_pin_rise = ack_s2 && !ack_prev;
  wire exp_shock = ctrl[CTRL_SHOCK_EXP];
  wire engineer = ctrl[CTRL_ENGINEER];
  // Expanded mode ignores the pin; only an engineer session write clears
  wire shock_ack = exp_shock ? (ack_cmd && engineer) : (ack_pin_rise && start_ok);
  wire il_ack = ack_cmd || (ack_pin_rise && !exp_shock);

  // A check ends early once the contact reaches its expected level
  assign win_stop = (state == SOFM_CHK_OPEN && !fb_closed) || (state == SOFM_CHK_CLOSE && fb_closed);

  // Each check starts the window timer on entry
  always_comb begin
    next_state = state;
    win_start = 1'b0;
    next_msg = display_msg_o;
    case (state)
      SOFM_OFF: begin
        if (ready_to_start && start_ok) begin
          if (!pre_check_ok) begin
            next_msg = MSG_FB_PRE;
          end else begin
            next_msg = MSG_NONE;
            next_state = fb_en ? SOFM_CHK_OPEN : SOFM_ON;
            win_start = fb_en;
          end
        end
      end
      SOFM_CHK_OPEN: begin
        if (!ready_to_start) begin
          next_state = fb_en ? SOFM_CHK_CLOSE : SOFM_OFF;
          win_start = fb_en;
        end else if (!fb_closed || !fb_en) begin
          // Contact opened or check disabled mid-window: release to ON rather than trip
          next_state = SOFM_ON;
        end else if (win_expired) begin
          next_state = SOFM_INTERLOCK;
          next_msg = MSG_FB_OPEN;
        end
      end
      SOFM_ON: begin
        if (!ready_to_start) begin
          next_state = fb_en ? SOFM_CHK_CLOSE : SOFM_OFF;
          win_start = fb_en;
        end
      end
      SOFM_CHK_CLOSE: begin
        if (fb_closed || !fb_en) begin
          next_state = SOFM_OFF;
        end else if (win_expired) begin
          next_state = SOFM_INTERLOCK;
          next_msg = MSG_FB_CLOSE;
        end
      end
      SOFM_INTERLOCK: begin
        // No timeout releases the interlock, only an acknowledge
        if (il_ack) begin
          next_state = SOFM_OFF;
          next_msg = MSG_NONE;
        end
      end
      default: begin
        // Unreachable codes fall back to off
        next_state = SOFM_OFF;
      end
    endcase
    if (shock_err && !shock_latched) begin
      next_msg = MSG_SHOCK;
    end
  end

  // One-cycle event strobes for the sticky status bits
  wire fb_fault_ev = (next_state == SOFM_INTERLOCK) && (state != SOFM_INTERLOCK);
  wire ref_fault_ev = ref_dev && !ref_fault;
  wire shock_ev = shock_err && !shock_latched;
  wire out_next = drives_outputs(next_state);
  wire on_ev = (state == SOFM_OFF) && out_next;
  wire off_ev = out_active && !out_next;
  wire [EV_W-1:0] events = {off_ev, on_ev, shock_ev, ref_fault_ev, fb_fault_ev};
  wire istat_clr = rd && sel_istat;
  wire [31:0] stat_word = {19'h0, 5'(state), 3'h0, fb_closed, shock_latched, ref_fault,
                           fault_interlock_o, safety_switched_output_o};
  // Read data is captured in the setup cycle so it stands through the access
  wire [31:0] rd_word = sel_ctrl ? ctrl :
                        sel_stat ? stat_word :
                        sel_istat ? irq_stat :
                        sel_imask ? irq_mask : 32'h0000_0000;


  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= SOFM_OFF;
      display_msg_o <= MSG_NONE;
    end else begin
      state <= next_state;
      display_msg_o <= next_msg;
    end
  end

  // Ack pin: two flops, a third for the edge; idle low so no edge after reset
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
      ack_prev <= 1'b0;
    end else begin
      ack_s1 <= ack_input_i;
      ack_s2 <= ack_s1;
      ack_prev <= ack_s2;
    end
  end

  // Deviation holds outputs off until acknowledged; a new event beats the ack
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ref_fault <= 1'b0;
    end else if (ref_dev) begin
      ref_fault <= 1'b1;
    end else if (il_ack) begin
      ref_fault <= 1'b0;
    end
  end

  // Shock error stays latched while the pin is still high
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      shock_latched <= 1'b0;
    end else if (shock_err) begin
      shock_latched <= 1'b1;
    end else if (shock_ack) begin
      shock_latched <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl <= CTRL_RST;
      irq_mask <= MASK_RST;
      irq_stat <= 32'h0000_0000;
    end else begin
      if (wr && sel_ctrl) begin
        ctrl <= {27'h0, pwdata_i[4:0]};
      end
      if (wr && sel_imask) begin
        irq_mask <= {27'h0, pwdata_i[EV_W-1:0]};
      end
      // Only bits the reader saw are cleared; set wins over the clear
      // An event arriving between setup and access stays pending
      irq_stat <= (istat_clr ? (irq_stat & ~prdata_o) : irq_stat) | {27'h0, events};
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      prdata_o <= rd_word;
    end
  end

  // Zero wait states: every access completes in its first access cycle
  assign pready_o = 1'b1;
  assign pslverr_o = apb_acc && !mapped;
  assign safety_switched_output_o = out_active && ready_to_start;
  assign fault_interlock_o = (state == SOFM_INTERLOCK);
  assign irq_o = |(irq_stat & irq_mask);

  // Field pair choice and reset-button timing stay outside this block
endmodule

/* tb/sofm_chk.sv */
// Port-level assertions for the output feedback monitor
`timescale 1ns/10ps
module sofm_chk (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic field_clear_i,
  input wire logic safety_switched_output_o,
  input wire logic fault_interlock_o,
  input wire logic [7:0] display_msg_o,
  input wire logic irq_o
);
  import sofm_pkg::*;
  logic acc;
  logic mapped;
  assign acc = psel_i && penable_i;
  assign mapped = paddr_i inside {CTRL_OFS, STAT_OFS, IRQ_STAT_OFS, IRQ_MASK_OFS, ACK_OFS};
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  chk_ilk_out_off: assert property (fault_interlock_o |-> !safety_switched_output_o)
    else $error("output on in interlock");
  // Three samples cover the two-flop synchroniser
  chk_field_drop: assert property (!field_clear_i [*3] |-> !safety_switched_output_o)
    else $error("output on with field violated");
  chk_fault_msg: assert property ($rose(fault_interlock_o) |-> ##[0:2] display_msg_o != MSG_NONE)
    else $error("no message on fault");
  chk_err_decode: assert property (acc |-> pslverr_o == !mapped)
    else $error("bad slave error");
  chk_err_idle: assert property (!acc |-> !pslverr_o)
    else $error("slave error outside access");
  chk_ready_high: assert property (pready_o)
    else $error("ready low");
  chk_rdata_hold: assert property (!(psel_i && !penable_i && !pwrite_i) |=> $stable(prdata_o))
    else $error("read data moved");
  chk_irq_fall: assert property ($fell(irq_o) |-> $past(acc && (paddr_i == IRQ_STAT_OFS || paddr_i == IRQ_MASK_OFS)))
    else $error("irq fell without cause");
  cover property ($rose(fault_interlock_o));
  cover property ($fell(irq_o));
  cover property (acc && pslverr_o);
endmodule
bind sofm_top sofm_chk sofm_chk_inst (.clk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .prdata_o,
  .pready_o, .pslverr_o, .field_clear_i, .safety_switched_output_o, .fault_interlock_o, .display_msg_o, .irq_o);

/* tb/sofm_contactor_model.sv */
// Downstream contactor with a normally closed feedback contact
`timescale 1ns/10ps
module sofm_contactor_model #(
  parameter int unsigned DLY_FAST = 3,
  parameter int unsigned DLY_SLOW = 30
) (
  input wire logic clk_i,
  input wire logic coil_i,
  input wire logic slow_i,
  input wire logic [1:0] fault_i,
  output logic feedback_o
);
  int unsigned cnt = 0;
  logic arm = 1'b0;
  always @(posedge clk_i) begin
    if (coil_i == arm) begin
      cnt <= 0;
    end else if (cnt >= (slow_i ? DLY_SLOW : DLY_FAST)) begin
      arm <= coil_i;
    end else begin
      cnt <= cnt + 1;
    end
  end
  // Fault 1 welds the contact shut, fault 2 breaks it open
  assign feedback_o = (fault_i == 2'h1) ? 1'b1 : (fault_i == 2'h2) ? 1'b0 : !arm;
endmodule

/* tb/sofm_tb_top.sv */
// Directed testbench for the output feedback monitor
`timescale 1ns/10ps
module sofm_tb_top;
  import sofm_pkg::*;
  logic clk, rstn, psel, pen, pwr, pready, err, fclr, rpres, rok, lock, shock, ack, out, ilk, irq, fb, slow;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [7:0] msg;
  logic [1:0] fault;
  int miscompares = 0;
  int cmp_count = 0;
  sofm_top #(.FB_WINDOW_CYCLES(50)) sofm_top_inst (.clk_i(clk), .resetn_i(rstn), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(err),
    .field_clear_i(fclr), .ref_area_present_i(rpres), .ref_contour_ok_i(rok), .start_restart_lock_i(lock),
    .contactor_feedback_input_i(fb), .shock_error_i(shock), .ack_input_i(ack), .safety_switched_output_o(out),
    .fault_interlock_o(ilk), .display_msg_o(msg), .irq_o(irq));
  sofm_contactor_model sofm_contactor_model_inst (.clk_i(clk), .coil_i(out), .slow_i(slow), .fault_i(fault),
    .feedback_o(fb));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic summarize;
    if (miscompares == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Sampled at the falling edge so the launching edge has settled
  task automatic cb(input string nm, input int n, input logic sel, input logic e);
    repeat (n) @(posedge clk);
    @(negedge clk);
    chk(nm, {31'h0, sel ? ilk : out}, {31'h0, e});
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      miscompares++;
      summarize();
    end
    q = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, q, e);
  endtask
  task automatic sbit(input int b, input logic e);
    apb(1'b0, STAT_OFS, 32'h0);
    chk("stat", {31'h0, q[b]}, {31'h0, e});
  endtask
  task automatic wt(input logic sel, input logic v, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while ((sel ? ilk : out) !== v && n < lim);
    if ((sel ? ilk : out) !== v) begin
      miscompares++;
      summarize();
    end
  endtask
  task automatic pulse_ack;
    @(posedge clk);
    ack <= 1'b1;
    repeat (4) @(posedge clk);
    ack <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  task automatic shk(input logic e);
    @(posedge clk);
    shock <= 1'b1;
    repeat (4) @(posedge clk);
    shock <= 1'b0;
    sbit(3, 1'b1);
    pulse_ack();
    sbit(3, e);
  endtask
  initial begin
    {psel, pen, pwr, fclr, rpres, shock, ack, slow, rstn} = '0;
    {lock, rok} = 2'b11;
    {paddr, pwdata, fault} = '0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    rd(CTRL_OFS, CTRL_RST, "ctrl");
    rd(IRQ_MASK_OFS, MASK_RST, "mask");
    rd(12'h020, 32'h0, "unmapped");
    chk("slverr", {31'h0, err}, 32'h1);
    apb(1'b1, IRQ_MASK_OFS, 32'h1F);
    apb(1'b1, CTRL_OFS, 32'h11);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      slow <= i[0];
      fclr <= 1'b1;
      wt(1'b0, 1'b1, 20);
      cb("on", 80, 1'b0, 1'b1);
      @(posedge clk);
      fclr <= 1'b0;
      cb("off", 80, 1'b1, 1'b0);
      rd(IRQ_STAT_OFS, 32'h18, "events");
    end
    // Start permission withheld by the upstream lock logic
    @(posedge clk);
    lock <= 1'b0;
    fclr <= 1'b1;
    cb("locked", 12, 1'b0, 1'b0);
    @(posedge clk);
    lock <= 1'b1;
    wt(1'b0, 1'b1, 20);
    @(posedge clk);
    fclr <= 1'b0;
    wt(1'b0, 1'b0, 10);
    repeat (80) @(posedge clk);
    @(posedge clk);
    fault <= 2'h1;
    fclr <= 1'b1;
    wt(1'b1, 1'b1, 80);
    cb("drop", 0, 1'b0, 1'b0);
    chk("msg", {24'h0, msg}, {24'h0, MSG_FB_OPEN});
    apb(1'b1, IRQ_MASK_OFS, 32'h0);
    @(negedge clk);
    chk("masked", {31'h0, irq}, 32'h0);
    apb(1'b1, IRQ_MASK_OFS, 32'h1F);
    @(negedge clk);
    chk("irq", {31'h0, irq}, 32'h1);
    apb(1'b0, IRQ_STAT_OFS, 32'h0);
    @(negedge clk);
    chk("irq_clr", {31'h0, irq}, 32'h0);
    @(posedge clk);
    fault <= 2'h0;
    fclr <= 1'b0;
    pulse_ack();
    wt(1'b1, 1'b0, 10);
    @(posedge clk);
    fault <= 2'h2;
    repeat (10) @(posedge clk);
    fclr <= 1'b1;
    cb("refuse", 30, 1'b0, 1'b0);
    chk("msg", {24'h0, msg}, {24'h0, MSG_FB_PRE});
    @(posedge clk);
    fault <= 2'h0;
    wt(1'b0, 1'b1, 20);
    // Let the contact open first so the close check starts from open
    repeat (60) @(posedge clk);
    fault <= 2'h2;
    fclr <= 1'b0;
    wt(1'b1, 1'b1, 80);
    chk("msg", {24'h0, msg}, {24'h0, MSG_FB_CLOSE});
    @(posedge clk);
    fault <= 2'h0;
    pulse_ack();
    wt(1'b1, 1'b0, 10);
    apb(1'b1, CTRL_OFS, 32'h12);
    @(posedge clk);
    fclr <= 1'b1;
    rpres <= 1'b1;
    wt(1'b0, 1'b1, 10);
    cb("contour", 6, 1'b0, 1'b1);
    @(posedge clk);
    rok <= 1'b0;
    wt(1'b0, 1'b0, 6);
    sbit(2, 1'b1);
    @(posedge clk);
    rok <= 1'b1;
    fclr <= 1'b0;
    pulse_ack();
    sbit(2, 1'b0);
    apb(1'b1, CTRL_OFS, 32'h14);
    shk(1'b1);
    apb(1'b1, ACK_OFS, ACK_KEY);
    sbit(3, 1'b1);
    apb(1'b1, CTRL_OFS, 32'h1C);
    apb(1'b1, ACK_OFS, ACK_KEY);
    sbit(3, 1'b0);
    apb(1'b1, CTRL_OFS, 32'h10);
    shk(1'b0);
    summarize();
  end
endmodule
